//--- common/strap_cfg_pkg.sv
`default_nettype none

package strap_cfg_pkg;

    // Resolved state of one four-level pin
    typedef enum logic [1:0] {LVL_GND, LVL_WEAK, LVL_FLOAT, LVL_SUPPLY} pin_level_t;

    // Configuration source selected by the mode pin
    typedef enum logic [1:0] {MODE_PIN, MODE_BUS_MASTER, MODE_BUS_SLAVE} bus_mode_t;

    // Per-channel configuration codes
    typedef struct packed {
        logic [7:0] eq;
        logic [2:0] deemphasis_code;
        logic [2:0] swing;
    } chan_cfg_t;

    // Comparator outputs per pin (thresholds 0.2, 0.5, 0.8 of supply)
    localparam int THERM_W = 3;
    localparam int PIN_COUNT = 8;

    // Timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SETTLE_US = 100;
    localparam int unsigned SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned POR_LIMIT_MS = 500;
    localparam int unsigned POR_LIMIT_CYCLES = POR_LIMIT_MS * (CLK_HZ / 1000);
    // Cycles after reset release before two resolved samples reflect the pins
    localparam int unsigned PIPE_CYCLES = 4;

    // Equalizer codes, index = upper level * 4 + lower level
    localparam logic [15:0][7:0] EQ_CODES = {
        8'hff, 8'hbf, 8'h7f, 8'haa, 8'h3f, 8'h2f, 8'h1f, 8'h55,
        8'h0f, 8'h0b, 8'h15, 8'h07, 8'h03, 8'h02, 8'h01, 8'h00
    };

    // De-emphasis codes
    localparam logic [2:0] DEM_CODE_GND = 3'h0;
    localparam logic [2:0] DEM_CODE_FLOAT = 3'h2;
    localparam logic [2:0] DEM_CODE_WEAK = 3'h3;
    localparam logic [2:0] DEM_CODE_SUPPLY = 3'h5;

    // Output swing codes
    localparam logic [2:0] SWING_CODE_GND = 3'h0;
    localparam logic [2:0] SWING_CODE_FLOAT = 3'h3;
    localparam logic [2:0] SWING_CODE_WEAK = 3'h5;
    localparam logic [2:0] SWING_CODE_SUPPLY_LO = 3'h4;
    localparam logic [2:0] SWING_CODE_SUPPLY_HI = 3'h6;
    localparam logic [2:0] SWING_A_PIN_MODE = 3'h0;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_SWING_A = 8'h23;
    localparam logic [7:0] REG_STATUS = 8'h40;
    localparam logic [7:0] REG_EQ_A = 8'h41;
    localparam logic [7:0] REG_EQ_B = 8'h42;
    localparam logic [7:0] REG_DEM = 8'h43;
    localparam logic [7:0] REG_SWING = 8'h44;
    localparam int SWING_A_LSB = 2;
    localparam logic [2:0] SWING_A_RESET = 3'h0;
    localparam logic [7:0] RD_ZERO = 8'h00;

endpackage : strap_cfg_pkg

`default_nettype wire

//--- rtl/level_resolver.sv
`default_nettype none

// Synchronises comparator outputs and resolves each pin to a level
module level_resolver #(
    parameter int N = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0][strap_cfg_pkg::THERM_W-1:0] therm_i,
    output logic [N-1:0][1:0] level_o
);

    logic [N-1:0][strap_cfg_pkg::THERM_W-1:0] sync_a;
    logic [N-1:0][strap_cfg_pkg::THERM_W-1:0] sync_b;
    logic [N-1:0][1:0] next_level;

    generate
        if (N < 1)
        begin : g_bad_n
            $error("level_resolver needs at least one pin");
        end
    endgenerate

    // Highest tripped threshold wins, so a broken thermometer still resolves
    function automatic logic [1:0] therm_to_level(input logic [2:0] t);
        if (t[2])
            return 2'(strap_cfg_pkg::LVL_SUPPLY);
        else if (t[1])
            return 2'(strap_cfg_pkg::LVL_FLOAT);
        else if (t[0])
            return 2'(strap_cfg_pkg::LVL_WEAK);
        else
            return 2'(strap_cfg_pkg::LVL_GND);
    endfunction : therm_to_level

    // Decode from the second sync stage only
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            next_level[i] = therm_to_level(sync_b[i]);
        end
    end

    // Two-stage synchroniser and level register
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sync_a <= '0;
            sync_b <= '0;
            level_o <= '0;
        end
        else
        begin
            sync_a <= therm_i;
            sync_b <= sync_a;
            level_o <= next_level;
        end
    end

endmodule : level_resolver

`default_nettype wire

//--- rtl/code_mapper.sv
`default_nettype none

// Maps resolved pin levels of one channel to configuration codes
module code_mapper (
    input wire logic [1:0] eq_upper_i,
    input wire logic [1:0] eq_lower_i,
    input wire logic [1:0] dem_i,
    input wire logic [1:0] swing_i,
    output strap_cfg_pkg::chan_cfg_t cfg_o
);

    // Equalizer lookup, upper pin major
    always_comb
    begin
        cfg_o.eq = strap_cfg_pkg::EQ_CODES[{eq_upper_i, eq_lower_i}];
    end

    // De-emphasis lookup
    always_comb
    begin
        case (dem_i)
            2'(strap_cfg_pkg::LVL_GND): cfg_o.deemphasis_code = strap_cfg_pkg::DEM_CODE_GND;
            2'(strap_cfg_pkg::LVL_FLOAT): cfg_o.deemphasis_code = strap_cfg_pkg::DEM_CODE_FLOAT;
            2'(strap_cfg_pkg::LVL_WEAK): cfg_o.deemphasis_code = strap_cfg_pkg::DEM_CODE_WEAK;
            default: cfg_o.deemphasis_code = strap_cfg_pkg::DEM_CODE_SUPPLY;
        endcase
    end

    // Swing lookup; supply level depends on de-emphasis strength
    always_comb
    begin
        case (swing_i)
            2'(strap_cfg_pkg::LVL_GND): cfg_o.swing = strap_cfg_pkg::SWING_CODE_GND;
            2'(strap_cfg_pkg::LVL_FLOAT): cfg_o.swing = strap_cfg_pkg::SWING_CODE_FLOAT;
            2'(strap_cfg_pkg::LVL_WEAK): cfg_o.swing = strap_cfg_pkg::SWING_CODE_WEAK;
            default:
            begin
                if (dem_i == 2'(strap_cfg_pkg::LVL_GND) || dem_i == 2'(strap_cfg_pkg::LVL_FLOAT))
                    cfg_o.swing = strap_cfg_pkg::SWING_CODE_SUPPLY_LO;
                else
                    cfg_o.swing = strap_cfg_pkg::SWING_CODE_SUPPLY_HI;
            end
        endcase
    end

endmodule : code_mapper

`default_nettype wire

//--- rtl/strap_config_loader.sv
`default_nettype none

// Resolves strap pins after reset, applies configuration, serves a register port
module strap_config_loader #(
    parameter int unsigned SETTLE_CYCLES = strap_cfg_pkg::SETTLE_CYCLES,
    parameter int unsigned POR_LIMIT_CYCLES = strap_cfg_pkg::POR_LIMIT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Comparator outputs of each four-level pin, index 0 = channel A
    input wire logic [1:0][strap_cfg_pkg::THERM_W-1:0] equalizer_select_upper_i,
    input wire logic [1:0][strap_cfg_pkg::THERM_W-1:0] equalizer_select_lower_i,
    input wire logic [1:0][strap_cfg_pkg::THERM_W-1:0] deemphasis_select_i,
    input wire logic [strap_cfg_pkg::THERM_W-1:0] output_swing_select_i,
    input wire logic [strap_cfg_pkg::THERM_W-1:0] mgmt_bus_mode_pin_i,
    // Register port
    input wire logic [strap_cfg_pkg::ADDR_W-1:0] addr_i,
    input wire logic [strap_cfg_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [strap_cfg_pkg::DATA_W-1:0] rd_data_o,
    // Applied configuration
    output strap_cfg_pkg::chan_cfg_t cfg_a_o,
    output strap_cfg_pkg::chan_cfg_t cfg_b_o,
    output strap_cfg_pkg::bus_mode_t mode_o,
    output logic ready_o
);

    typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} load_state_t;

    // Refuse counts the counters cannot serve or that break the deadline
    generate
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= POR_LIMIT_CYCLES)
        begin : g_bad_settle
            $error("settle count must be at least one and below the deadline");
        end
    endgenerate

    // A quiet board must be able to settle before the deadline forces a load
    generate
        if (SETTLE_CYCLES + strap_cfg_pkg::PIPE_CYCLES >= POR_LIMIT_CYCLES)
        begin : g_bad_deadline
            $error("settle plus pipeline fill must end before the deadline");
        end
    endgenerate

    localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYCLES - 1);
    localparam logic [31:0] POR_LAST = 32'(POR_LIMIT_CYCLES - 2);
    localparam logic [31:0] PIPE_LAST = 32'(strap_cfg_pkg::PIPE_CYCLES);

    logic [strap_cfg_pkg::PIN_COUNT-1:0][strap_cfg_pkg::THERM_W-1:0] pin_therm;
    logic [strap_cfg_pkg::PIN_COUNT-1:0][1:0] level;
    logic [strap_cfg_pkg::PIN_COUNT-1:0][1:0] prev_level;
    logic [strap_cfg_pkg::PIN_COUNT-1:0][1:0] next_prev_level;
    strap_cfg_pkg::chan_cfg_t map_a;
    strap_cfg_pkg::chan_cfg_t map_b;

    load_state_t state;
    load_state_t next_state;
    logic [31:0] settle_cnt;
    logic [31:0] next_settle_cnt;
    logic [31:0] por_cnt;
    logic [31:0] next_por_cnt;
    logic pins_moved;
    logic pipe_full;

    strap_cfg_pkg::chan_cfg_t held_a;
    strap_cfg_pkg::chan_cfg_t held_b;
    strap_cfg_pkg::bus_mode_t held_mode;
    strap_cfg_pkg::chan_cfg_t next_held_a;
    strap_cfg_pkg::chan_cfg_t next_held_b;
    strap_cfg_pkg::bus_mode_t next_held_mode;
    strap_cfg_pkg::bus_mode_t pin_mode;

    logic [2:0] swing_a_reg;
    logic [2:0] next_swing_a_reg;
    logic [strap_cfg_pkg::DATA_W-1:0] next_rd_data;
    strap_cfg_pkg::chan_cfg_t next_cfg_a;
    strap_cfg_pkg::chan_cfg_t next_cfg_b;
    strap_cfg_pkg::bus_mode_t next_mode;
    logic next_ready;

    // Pin order: upper A/B, lower A/B, de-emphasis A/B, swing, mode
    assign pin_therm = {mgmt_bus_mode_pin_i, output_swing_select_i,
                        deemphasis_select_i, equalizer_select_lower_i,
                        equalizer_select_upper_i};

    // Synchronise and resolve all strap pins
    level_resolver #(
        .N(strap_cfg_pkg::PIN_COUNT)
    ) u_resolver (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .therm_i(pin_therm),
        .level_o(level)
    );

    // Channel A codes from live levels
    code_mapper u_map_a (
        .eq_upper_i(level[0]),
        .eq_lower_i(level[2]),
        .dem_i(level[4]),
        .swing_i(level[6]),
        .cfg_o(map_a)
    );

    // Channel B codes; swing pin is shared
    code_mapper u_map_b (
        .eq_upper_i(level[1]),
        .eq_lower_i(level[3]),
        .dem_i(level[5]),
        .swing_i(level[6]),
        .cfg_o(map_b)
    );

    // Mode pin decode
    always_comb
    begin
        if (level[7] == 2'(strap_cfg_pkg::LVL_SUPPLY))
            pin_mode = strap_cfg_pkg::MODE_BUS_SLAVE;
        else if (level[7] == 2'(strap_cfg_pkg::LVL_FLOAT))
            pin_mode = strap_cfg_pkg::MODE_BUS_MASTER;
        else
            pin_mode = strap_cfg_pkg::MODE_PIN;
    end

    // Change detect; sync stages still hold reset zeros right after release
    always_comb
    begin
        pins_moved = (level != prev_level);
        pipe_full = (por_cnt >= PIPE_LAST);
    end

    // Load sequencer: wait for quiet pins, but never past the deadline
    always_comb
    begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_por_cnt = por_cnt;
        next_prev_level = level;
        next_held_a = held_a;
        next_held_b = held_b;
        next_held_mode = held_mode;
        case (state)
            ST_SETTLE:
            begin
                next_por_cnt = por_cnt + 32'h1;
                // Stale zeros in the pipeline must not count as quiet pins
                if (pins_moved || !pipe_full)
                    next_settle_cnt = '0;
                else
                    next_settle_cnt = settle_cnt + 32'h1;
                if (!pins_moved && pipe_full && settle_cnt >= SETTLE_LAST)
                    next_state = ST_LOAD;
                if (por_cnt >= POR_LAST)
                    next_state = ST_LOAD;
            end
            ST_LOAD:
            begin
                next_held_a = map_a;
                next_held_b = map_b;
                next_held_mode = pin_mode;
                next_state = ST_RUN;
            end
            ST_RUN:
            begin
                next_state = ST_RUN;
            end
            default:
            begin
                next_state = ST_SETTLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_SETTLE;
            settle_cnt <= '0;
            por_cnt <= '0;
            prev_level <= '0;
            held_a <= '0;
            held_b <= '0;
            held_mode <= strap_cfg_pkg::MODE_PIN;
        end
        else
        begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            por_cnt <= next_por_cnt;
            prev_level <= next_prev_level;
            held_a <= next_held_a;
            held_b <= next_held_b;
            held_mode <= next_held_mode;
        end
    end

    // Register writes and read mux
    always_comb
    begin
        next_swing_a_reg = swing_a_reg;
        next_rd_data = strap_cfg_pkg::RD_ZERO;
        if (wr_i && addr_i == strap_cfg_pkg::REG_SWING_A)
            next_swing_a_reg = wr_data_i[strap_cfg_pkg::SWING_A_LSB +: 3];
        if (rd_i)
        begin
            if (addr_i == strap_cfg_pkg::REG_SWING_A)
                next_rd_data = {3'h0, swing_a_reg, 2'h0};
            else if (addr_i == strap_cfg_pkg::REG_STATUS)
                next_rd_data = {5'h00, ready_o, mode_o};
            else if (addr_i == strap_cfg_pkg::REG_EQ_A)
                next_rd_data = cfg_a_o.eq;
            else if (addr_i == strap_cfg_pkg::REG_EQ_B)
                next_rd_data = cfg_b_o.eq;
            else if (addr_i == strap_cfg_pkg::REG_DEM)
                next_rd_data = {1'b0, cfg_b_o.deemphasis_code, 1'b0, cfg_a_o.deemphasis_code};
            else if (addr_i == strap_cfg_pkg::REG_SWING)
                next_rd_data = {1'b0, cfg_b_o.swing, 1'b0, cfg_a_o.swing};
            else
                next_rd_data = strap_cfg_pkg::RD_ZERO;
        end
    end

    // Applied outputs; channel A swing depends on the mode
    always_comb
    begin
        next_cfg_a = cfg_a_o;
        next_cfg_b = cfg_b_o;
        next_mode = mode_o;
        next_ready = ready_o;
        if (state == ST_RUN)
        begin
            next_cfg_a = held_a;
            next_cfg_b = held_b;
            next_mode = held_mode;
            next_ready = 1'b1;
            if (held_mode == strap_cfg_pkg::MODE_PIN)
                next_cfg_a.swing = strap_cfg_pkg::SWING_A_PIN_MODE;
            else
                next_cfg_a.swing = swing_a_reg;
        end
    end

    // Register file and output flops
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            swing_a_reg <= strap_cfg_pkg::SWING_A_RESET;
            rd_data_o <= strap_cfg_pkg::RD_ZERO;
            cfg_a_o <= '0;
            cfg_b_o <= '0;
            mode_o <= strap_cfg_pkg::MODE_PIN;
            ready_o <= 1'b0;
        end
        else
        begin
            swing_a_reg <= next_swing_a_reg;
            rd_data_o <= next_rd_data;
            cfg_a_o <= next_cfg_a;
            cfg_b_o <= next_cfg_b;
            mode_o <= next_mode;
            ready_o <= next_ready;
        end
    end

endmodule : strap_config_loader

`default_nettype wire

//--- tb/strap_board.sv
`default_nettype none

// Board straps: resolved level to comparator thermometer
module strap_board (
    input wire logic [7:0][1:0] level_i,
    output logic [7:0][2:0] therm_o
);
    // 0 ground, 1 weak, 2 float, 3 supply
    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            therm_o[k] = 3'(8'hf4 >> (2 * level_i[k]) & 8'h03) | {level_i[k] == 2'h3, 2'h0};
        end
    end
endmodule : strap_board

`default_nettype wire

//--- tb/strap_config_loader_monitor.sv
`default_nettype none

// Port-level checks of the strap loader
module strap_config_loader_monitor #(
    parameter int unsigned SETTLE_CYCLES = 4,
    parameter int unsigned POR_LIMIT_CYCLES = 40
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rd_data_o,
    input wire strap_cfg_pkg::chan_cfg_t cfg_a_o,
    input wire strap_cfg_pkg::chan_cfg_t cfg_b_o,
    input wire strap_cfg_pkg::bus_mode_t mode_o,
    input wire logic ready_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] since;
    logic [31:0] next_since;
    // Cycles since reset release, saturating
    always_comb
    begin
        next_since = (since == 32'hffffffff) ? since : since + 32'h1;
    end
    always_ff @(posedge sys_clk_i)
    begin
        since <= rst_i ? 32'h0 : next_since;
    end
    property p_ready_hold; ready_o |=> ready_o; endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
    property p_held;
        $past(ready_o) && ready_o |-> $stable(cfg_b_o) && $stable(mode_o) && $stable(cfg_a_o.eq);
    endproperty
    a_held: assert property (p_held) else $error("config moved after load");
    property p_pin_swing; ready_o && mode_o == strap_cfg_pkg::MODE_PIN |-> cfg_a_o.swing == 3'h0;
    endproperty
    a_pin_swing: assert property (p_pin_swing) else $error("swing A not 700 mV");
    property p_bus_swing;
        wr_i && addr_i == 8'h23 && ready_o && mode_o != strap_cfg_pkg::MODE_PIN
            |-> ##2 cfg_a_o.swing == $past(wr_data_i[4:2], 2);
    endproperty
    a_bus_swing: assert property (p_bus_swing) else $error("swing A not from register");
    property p_deadline; since > POR_LIMIT_CYCLES + 3 |-> ready_o; endproperty
    a_deadline: assert property (p_deadline) else $error("not ready by deadline");
    property p_early; ready_o |-> since >= SETTLE_CYCLES; endproperty
    a_early: assert property (p_early) else $error("ready before settle");
    property p_dem; $rose(ready_o) |-> cfg_b_o.deemphasis_code inside {3'h0, 3'h2, 3'h3, 3'h5}; endproperty
    a_dem: assert property (p_dem) else $error("bad de-emphasis code");
    property p_swing;
        $rose(ready_o) |-> (cfg_b_o.swing inside {3'h0, 3'h3, 3'h5})
            || (cfg_b_o.swing == 3'h4 && cfg_b_o.deemphasis_code inside {3'h0, 3'h2})
            || (cfg_b_o.swing == 3'h6 && cfg_b_o.deemphasis_code inside {3'h3, 3'h5});
    endproperty
    a_swing: assert property (p_swing) else $error("bad swing code");
    property p_rd_idle; !$past(rd_i) |-> rd_data_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    c_ready: cover property ($rose(ready_o));
    c_slave: cover property (ready_o && mode_o == strap_cfg_pkg::MODE_BUS_SLAVE);
    c_bus_wr: cover property (wr_i && ready_o && mode_o != strap_cfg_pkg::MODE_PIN);
endmodule : strap_config_loader_monitor

bind strap_config_loader strap_config_loader_monitor #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .POR_LIMIT_CYCLES(POR_LIMIT_CYCLES)
) u_mon (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .cfg_a_o(cfg_a_o),
    .cfg_b_o(cfg_b_o), .mode_o(mode_o), .ready_o(ready_o)
);

`default_nettype wire

//--- tb/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 4;
    localparam int PC = 40;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic [7:0][1:0] lv = '0;
    logic [7:0][2:0] th;
    logic [7:0] rd_data_o;
    strap_cfg_pkg::chan_cfg_t cfg_a_o;
    strap_cfg_pkg::chan_cfg_t cfg_b_o;
    strap_cfg_pkg::bus_mode_t mode_o;
    logic ready_o;
    logic [7:0] rdq[$];
    logic [29:0] cfq[$];
    logic rd_q = 1'b0;
    logic rdy_q = 1'b0;
    int miscompares = 0;
    int checks = 0;
    integer seed = 32'hc488eb6b;
    logic [7:0] d;
    logic [7:0] x_eqa;
    logic [2:0] x_dema;
    logic [2:0] x_demb;
    logic [2:0] x_swb;
    logic [7:0] eq_tab [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0b, 8'h0f,
        8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf, 8'hff};
    logic [2:0] dem_tab [4] = '{3'h0, 3'h3, 3'h2, 3'h5};
    logic [2:0] sw_tab [4] = '{3'h0, 3'h5, 3'h3, 3'h4};

    initial
    begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    strap_board u_board (.level_i(lv), .therm_o(th));

    strap_config_loader #(.SETTLE_CYCLES(SC), .POR_LIMIT_CYCLES(PC)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .equalizer_select_upper_i({th[1], th[0]}), .equalizer_select_lower_i({th[3], th[2]}),
        .deemphasis_select_i({th[5], th[4]}), .output_swing_select_i(th[6]),
        .mgmt_bus_mode_pin_i(th[7]), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
        .rd_i(rd_i), .rd_data_o(rd_data_o), .cfg_a_o(cfg_a_o), .cfg_b_o(cfg_b_o),
        .mode_o(mode_o), .ready_o(ready_o)
    );

    task automatic close_out();
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // Strap one combination, reset, wait for load; ch churns the mode pin
    task automatic run(input int i, input int m, input bit ch, input int rl);
        int n;
        int u;
        int l;
        u = i / 4;
        l = i % 4;
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        lv <= {2'(m), 2'((l + u) % 4), 2'(u), 2'(l), 2'(u), 2'(l), 2'(l), 2'(u)};
        x_eqa = eq_tab[i];
        x_dema = dem_tab[l];
        x_demb = dem_tab[u];
        x_swb = (u == 1 || u == 3) && (l + u) % 4 == 3 ? 3'h6 : sw_tab[(l + u) % 4];
        cfq.push_back({x_eqa, x_dema, 3'h0, eq_tab[l * 4 + u], x_demb, x_swb,
            m == 3 ? 2'h2 : (m == 2 ? 2'h1 : 2'h0)});
        repeat (rl) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        n = 0;
        while (ready_o !== 1'b1 && n < 60)
        begin
            @(posedge sys_clk_i);
            if (ch)
                lv[7] <= lv[7] ^ 2'h1;
            n++;
        end
        checks++;
        if (n >= 60 || (ch && n < PC))
        begin
            miscompares++;
            $display("unexpected at %0t: load time %0d", $time, n);
            close_out();
        end
        repeat (2) @(posedge sys_clk_i);
    endtask : run

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        rdq.push_back(e);
    endtask : rd

    task automatic idle();
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask : idle

    // Result watcher: read slot and configuration load
    always @(posedge sys_clk_i)
    begin
        if (rd_q === 1'b1)
        begin
            checks++;
            if (rd_data_o !== rdq.pop_front())
            begin
                miscompares++;
                $display("unexpected at %0t: read data %h", $time, rd_data_o);
            end
        end
        if (ready_o === 1'b1 && rdy_q === 1'b0)
        begin
            checks++;
            if ({cfg_a_o, cfg_b_o, mode_o} !== cfq.pop_front())
            begin
                miscompares++;
                $display("unexpected at %0t: loaded config", $time);
            end
        end
        rd_q <= rd_i;
        rdy_q <= ready_o;
    end

    // Main sequence
    initial
    begin
        run(0, 0, 1'b1, 20);
        for (int i = 1; i < 16; i++)
            run(i, $random(seed) & 3, 1'b0, 3);
        run(9, 1, 1'b0, 3);
        wr(8'h23, 8'h1c);
        rd(8'h44, {1'b0, x_swb, 4'h0});
        run(6, 3, 1'b0, 3);
        d = $random(seed);
        wr(8'h23, d);
        rd(8'h23, {3'h0, d[4:2], 2'h0});
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h06);
        rd(8'h10, 8'h00);
        rd(8'h44, {1'b0, x_swb, 1'b0, d[4:2]});
        idle();
        lv <= ~lv;
        repeat (8) @(posedge sys_clk_i);
        rd(8'h41, x_eqa);
        rd(8'h43, {1'b0, x_demb, 1'b0, x_dema});
        idle();
        repeat (4) @(posedge sys_clk_i);
        close_out();
    end
endmodule : tb

`default_nettype wire
